/* rtl/ccdt_timing_gen.v */
// ccd readout timing generator: drives every clocked sensor pin
// assumes level translation to sensor voltages outside; one clock, registered outputs except busy, decoded from state
`include "ccdt_map.vh"

// Summary of operation
// - each pin gets one of seven patterns
// - clock at least 572 or 1144 lines
// - vertical rises at walk steps 1 to 3 come in the same cycle as matching falls
// - at least 1013 or 2026 pixels per line
// - optional substrate pulse starts exposure
// - last phase copies phase-two storage clock
// - unused c/d registers clocked or held off
// - slow c/d clock is integer multiple
module ccdt_timing_gen #(
   parameter LINES_HALF = `CCDT_LINES_HALF,
   parameter LINES_FULL = `CCDT_LINES_FULL,
   parameter PIX_DUAL   = `CCDT_PIX_DUAL,
   parameter PIX_SINGLE = `CCDT_PIX_SINGLE,
   parameter T_3P_NS    = `CCDT_T_3P_NS,
   parameter T_3D_NS    = `CCDT_T_3D_NS,
   parameter T_PD_NS    = `CCDT_T_PD_NS,
   parameter CD_DIV     = 1
) (
   input  wire        clk_sys,
   input  wire        nrst,
   input  wire        start,
   input  wire [1:0]  mode,
   input  wire        shutter_en,
   input  wire [15:0] expose_lines,
   input  wire        cd_off,
   output wire        busy,
   output reg         frame_done,
   output reg         vert_phase1_top,
   output reg         vert_phase2_top,
   output reg         vert_phase3_top,
   output reg         vert_phase4_top,
   output reg         vert_phase1_bottom,
   output reg         vert_phase2_bottom,
   output reg         vert_phase3_bottom,
   output reg         vert_phase4_bottom,
   output reg         v1_third_level,
   output reg  [3:0]  horiz_ph1_storage,
   output reg  [3:0]  horiz_ph1_barrier,
   output reg  [3:0]  horiz_ph2_storage,
   output reg  [3:0]  horiz_ph2_barrier,
   output reg  [3:0]  last_horiz_phase,
   output reg  [3:0]  reset_gate,
   output reg  [3:0]  cd_off_level,
   output reg         substrate_pulse,
   output reg         pixel_valid
);

   // -----------------------------------------------------------------
   // timing counts
   // -----------------------------------------------------------------
   function [15:0] ccdt_cyc;
      input integer ns;
      integer c;
      begin
         c = (ns + `CCDT_CLK_NS - 1) / `CCDT_CLK_NS;
         if (c < 1) c = 1;
         ccdt_cyc = c[15:0];
      end
   endfunction

   localparam [15:0] C_SUB = ccdt_cyc(`CCDT_T_SUB_NS);
   localparam [15:0] C_HD  = ccdt_cyc(`CCDT_T_HD_NS);
   localparam [15:0] C_3P  = ccdt_cyc(T_3P_NS);
   localparam [15:0] C_PD  = ccdt_cyc(T_PD_NS);
   localparam [15:0] C_3D  = ccdt_cyc(T_3D_NS);
   localparam [15:0] C_V   = ccdt_cyc(`CCDT_T_V_NS);
   localparam [15:0] C_HS  = ccdt_cyc(`CCDT_T_HS_NS);
   localparam [15:0] C_E   = ccdt_cyc(`CCDT_T_E_NS);

   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_SUB  = 4'h1;
   localparam [3:0] S_HD   = 4'h2;
   localparam [3:0] S_EXP  = 4'h3;
   localparam [3:0] S_3P   = 4'h4;
   localparam [3:0] S_PD   = 4'h5;
   localparam [3:0] S_3D   = 4'h6;
   localparam [3:0] S_VS   = 4'h7;
   localparam [3:0] S_HS   = 4'h8;
   localparam [3:0] S_PIX  = 4'h9;

   reg [3:0]  state_q;
   reg [15:0] tmr_q;
   reg [2:0]  vph_q;
   reg [15:0] line_q;
   reg [15:0] pix_q;
   reg        hph_q;
   reg [7:0]  cdiv_q;
   reg        hcd_q;
   reg [1:0]  mode_q;
   reg        sh_q;
   reg [15:0] exp_q;
   reg        cdoff_q;

   wire        full_v = (mode_q == `CCDT_MODE_DUAL_AB) || (mode_q == `CCDT_MODE_SINGLE);
   wire        one_h  = (mode_q == `CCDT_MODE_SINGLE);
   wire [15:0] n_lin  = full_v ? LINES_FULL[15:0] : LINES_HALF[15:0];
   wire [15:0] n_pix  = one_h ? PIX_SINGLE[15:0] : PIX_DUAL[15:0];
   // dual a/c turns the d register round to feed c, so c and d run together
   wire        cd_used = (mode_q == `CCDT_MODE_QUAD) || (mode_q == `CCDT_MODE_DUAL_AC);

   assign busy = (state_q != S_IDLE);

   // -----------------------------------------------------------------
   // frame sequencer
   // -----------------------------------------------------------------
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= S_IDLE;
         tmr_q   <= 16'h0000;
         vph_q   <= 3'h0;
         line_q  <= 16'h0000;
         pix_q   <= 16'h0000;
         hph_q   <= 1'b0;
         mode_q  <= 2'h0;
         sh_q    <= 1'b0;
         exp_q   <= 16'h0000;
         cdoff_q <= 1'b0;
         frame_done <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         tmr_q <= tmr_q + 16'h0001;
         case (state_q)
            S_IDLE: begin
               tmr_q <= 16'h0000;
               if (start) begin
                  mode_q  <= mode;
                  sh_q    <= shutter_en;
                  exp_q   <= expose_lines;
                  cdoff_q <= cd_off;
                  state_q <= shutter_en ? S_SUB : S_3P;
               end
            end
            S_SUB: if (tmr_q == C_SUB - 16'h0001) begin
               tmr_q <= 16'h0000;
               state_q <= S_HD;
            end
            S_HD: if (tmr_q == C_HD - 16'h0001) begin
               tmr_q <= 16'h0000;
               state_q <= S_EXP;
            end
            // exposure wait counted in clock cycles
            S_EXP: if (tmr_q >= exp_q) begin
               tmr_q <= 16'h0000;
               state_q <= S_3P;
            end
            S_3P: if (tmr_q == C_3P - 16'h0001) begin
               tmr_q <= 16'h0000;
               state_q <= S_PD;
            end
            S_PD: if (tmr_q == C_PD - 16'h0001) begin
               tmr_q <= 16'h0000;
               state_q <= S_3D;
            end
            S_3D: if (tmr_q == C_3D - 16'h0001) begin
               // the first shift also drops the dummy row onto the first dark row
               tmr_q <= 16'h0000;
               line_q <= 16'h0000;
               vph_q <= 3'h0;
               state_q <= S_VS;
            end
            S_VS: if (tmr_q == C_V - 16'h0001) begin
               tmr_q <= 16'h0000;
               vph_q <= vph_q + 3'h1;
               if (vph_q == 3'h3) state_q <= S_HS;
            end
            S_HS: if (tmr_q == C_HS - 16'h0001) begin
               tmr_q <= 16'h0000;
               pix_q <= 16'h0000;
               hph_q <= 1'b0;
               state_q <= S_PIX;
            end
            S_PIX: if (tmr_q == C_E - 16'h0001) begin
               tmr_q <= 16'h0000;
               hph_q <= ~hph_q;
               if (hph_q) begin
                  pix_q <= pix_q + 16'h0001;
                  if (pix_q == n_pix - 16'h0001) begin
                     line_q <= line_q + 16'h0001;
                     vph_q <= 3'h0;
                     if (line_q == n_lin - 16'h0001) begin
                        frame_done <= 1'b1;
                        state_q <= S_IDLE;
                     end else begin
                        state_q <= S_VS;
                     end
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // c/d divider: whole multiple of the a/b pixel clock
   // -----------------------------------------------------------------
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cdiv_q <= 8'h00;
         hcd_q  <= 1'b0;
      end else if (state_q != S_PIX) begin
         cdiv_q <= 8'h00;
         hcd_q  <= 1'b0;
      end else if (tmr_q == C_E - 16'h0001) begin
         if (cdiv_q == CD_DIV[7:0] - 8'h01) begin
            cdiv_q <= 8'h00;
            hcd_q  <= ~hcd_q;
         end else begin
            cdiv_q <= cdiv_q + 8'h01;
         end
      end
   end

   // -----------------------------------------------------------------
   // pin patterns
   // -----------------------------------------------------------------
   // vertical patterns: four-phase walk; steps 1 to 3 raise the next phase in
   // the same cycle the previous one falls; step 0 raises alone after the first line, and HS entry drops phase one alone
   reg [3:0] vp;
   reg       v1_hi, pd_lvl;
   always @* begin
      vp = 4'h1;
      case (vph_q)
         3'h0: vp = 4'h3;
         3'h1: vp = 4'h6;
         3'h2: vp = 4'hC;
         3'h3: vp = 4'h9;
         default: vp = 4'h1;
      endcase
      if (state_q != S_VS) vp = 4'h1;
      pd_lvl = (state_q == S_PD);
      v1_hi  = (state_q == S_3P) || pd_lvl || (state_q == S_3D);
   end

   reg hp1, hp2, rg, c1, c2;
   always @* begin
      hp1 = (state_q == S_PIX) ? ~hph_q : 1'b1;
      hp2 = ~hp1;
      rg  = (state_q == S_PIX) && !hph_q && (tmr_q == 16'h0000);
      c1  = (state_q == S_PIX) ? ~hcd_q : 1'b1;
      c2  = ~c1;
   end
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         {vert_phase1_top, vert_phase2_top, vert_phase3_top, vert_phase4_top} <= 4'h1;
         {vert_phase1_bottom, vert_phase2_bottom, vert_phase3_bottom,
          vert_phase4_bottom} <= 4'h1;
         v1_third_level    <= 1'b0;
         horiz_ph1_storage <= 4'h0;
         horiz_ph1_barrier <= 4'h0;
         horiz_ph2_storage <= 4'h0;
         horiz_ph2_barrier <= 4'h0;
         last_horiz_phase  <= 4'h0;
         reset_gate        <= 4'h0;
         cd_off_level      <= 4'h0;
         substrate_pulse   <= 1'b0;
         pixel_valid       <= 1'b0;
      end else begin
         {vert_phase1_bottom, vert_phase2_bottom, vert_phase3_bottom,
          vert_phase4_bottom} <= vp | {v1_hi, 3'h0};
         // a/b modes route top phases crosswise
         if (full_v) begin
            {vert_phase1_top, vert_phase2_top, vert_phase3_top, vert_phase4_top}
               <= {vp[3] | v1_hi, vp[0], vp[1], vp[2]};
         end else begin
            {vert_phase1_top, vert_phase2_top, vert_phase3_top, vert_phase4_top}
               <= vp | {v1_hi, 3'h0};
         end
         v1_third_level <= pd_lvl;
         // b register: single mode turns it round so it feeds a
         horiz_ph1_storage <= {c1, c1, one_h ? hp1 : hp1, hp1};
         horiz_ph1_barrier <= {mode_q == `CCDT_MODE_DUAL_AC ? c2 : c1, c1,
                               one_h ? hp2 : hp1, hp1};
         horiz_ph2_storage <= {c2, c2, hp2, hp2};
         horiz_ph2_barrier <= {mode_q == `CCDT_MODE_DUAL_AC ? c1 : c2, c2,
                               one_h ? hp1 : hp2, hp2};
         last_horiz_phase  <= {c2, c2, hp2, hp2};
         reset_gate        <= {rg, rg, rg, rg};
         // unused c/d either clock normally or sit off; b is turned round, never off
         cd_off_level <= {cdoff_q & ~cd_used, cdoff_q & ~cd_used, 2'h0};
         substrate_pulse <= (state_q == S_SUB) && sh_q;
         // pixel leaves on the falling edge of the last phase
         pixel_valid <= (state_q == S_PIX) && hph_q && (tmr_q == C_E - 16'h0001);
      end
   end

endmodule

/* shared/ccdt_map.vh */
// constants of the ccd readout timing generator
// assumes inclusion by bare name from the one design file
`ifndef CCDT_MAP_VH
`define CCDT_MAP_VH
// readout modes
`define CCDT_MODE_QUAD      2'h0
`define CCDT_MODE_DUAL_AB   2'h1
`define CCDT_MODE_DUAL_AC   2'h2
`define CCDT_MODE_SINGLE    2'h3
// least line and pixel counts per frame / line
`define CCDT_LINES_HALF     572
`define CCDT_LINES_FULL     1144
`define CCDT_PIX_DUAL       1013
`define CCDT_PIX_SINGLE     2026
// times in ns at 100 MHz clock (10 ns period)
`define CCDT_CLK_NS         10
`define CCDT_T_SUB_NS       1000
`define CCDT_T_HD_NS        1000
`define CCDT_T_PD_NS        1000
`define CCDT_T_3P_NS        4000
`define CCDT_T_3D_NS        4000
`define CCDT_T_D_NS         1000
`define CCDT_T_V_NS         1000
`define CCDT_T_HS_NS        200
`define CCDT_T_E_NS         25
`endif

/* test/ccdt_sensor_model.sv */
// behavioural model of the sensor charge path
// assumes logic-level clocks from the generator and a clear pulse between frames
module ccdt_sensor_model (
   input  wire logic clear,
   input  wire logic vert_phase1_bottom,
   input  wire logic v1_third_level,
   input  wire logic last_horiz_a,
   output int        row_count,
   output int        pix_count,
   output logic      video_out_a
);
   timeunit 1ns;
   timeprecision 1ns;
   logic merge_pend = 1'b0;
   // ----
   // charge path
   // ----
   // dummy row rides with the first dark row, so the transfer edge adds no line
   always @(posedge clear or posedge v1_third_level or negedge vert_phase1_bottom) begin
      if (clear) begin
         row_count = 0;
         merge_pend = 1'b0;
      end else if (v1_third_level) begin
         merge_pend = 1'b1;
      end else if (merge_pend) begin
         merge_pend = 1'b0;
      end else begin
         row_count = row_count + 1;
      end
   end
   // the video line flips each pixel, so a stale level is never shown
   always @(posedge clear or negedge last_horiz_a) begin
      if (clear) begin
         pix_count = 0;
         video_out_a = 1'b0;
      end else begin
         pix_count = pix_count + 1;
         video_out_a = ~video_out_a;
      end
   end
endmodule

/* test/ccdt_timing_gen_assertions.sv */
// port checker of the timing generator
// assumes a single clock domain and a bind onto every instance
module ccdt_timing_gen_checker (
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic       start,
   input wire logic       busy,
   input wire logic       frame_done,
   input wire logic       vert_phase1_top,
   input wire logic       vert_phase2_top,
   input wire logic       vert_phase3_top,
   input wire logic       vert_phase4_top,
   input wire logic       v1_third_level,
   input wire logic [3:0] horiz_ph2_storage,
   input wire logic [3:0] last_horiz_phase,
   input wire logic [3:0] cd_off_level,
   input wire logic       substrate_pulse,
   input wire logic       pixel_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ----
   // pulse widths, saturating so a long pulse never wraps
   // ----
   logic [7:0] sub_cnt_q;
   logic [7:0] pd_cnt_q;
   wire  [7:0] sub_cnt_d = substrate_pulse ? sub_cnt_q + {7'h00, ~&sub_cnt_q} : 8'h00;
   wire  [7:0] pd_cnt_d  = v1_third_level ? pd_cnt_q + {7'h00, ~&pd_cnt_q} : 8'h00;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sub_cnt_q <= 8'h00;
         pd_cnt_q  <= 8'h00;
      end else begin
         sub_cnt_q <= sub_cnt_d;
         pd_cnt_q  <= pd_cnt_d;
      end
   end
   // ----
   // properties
   // ----
   sequence s_take; !busy && start; endsequence
   sequence s_end; frame_done ##1 (!frame_done && !busy); endsequence
   property p_take; s_take |=> busy; endproperty
   property p_end; frame_done |-> s_end; endproperty
   property p_last; last_horiz_phase == horiz_ph2_storage; endproperty
   property p_ab_used; cd_off_level[1:0] == 2'h0; endproperty
   property p_sub_idle; !busy |-> !substrate_pulse; endproperty
   property p_sub_wide; $fell(substrate_pulse) |-> sub_cnt_q >= 8'h64; endproperty
   property p_pd_wide; $fell(v1_third_level) |-> pd_cnt_q >= 8'h64; endproperty
   property p_overlap;
      busy |-> (vert_phase1_top || vert_phase2_top || vert_phase3_top || vert_phase4_top);
   endproperty
   // the last pixel flag stands in the first idle cycle, beside frame_done
   property p_pix_busy; pixel_valid |-> $past(busy); endproperty
   a_take: assert property (p_take) else $error("idle start did not raise busy");
   a_end: assert property (p_end) else $error("frame end not a lone pulse");
   a_last: assert property (p_last) else $error("last phase differs");
   a_ab_used: assert property (p_ab_used) else $error("a or b held off");
   a_sub_idle: assert property (p_sub_idle) else $error("shutter pulse in idle");
   a_sub_wide: assert property (p_sub_wide) else $error("shutter pulse short");
   a_pd_wide: assert property (p_pd_wide) else $error("transfer level short");
   a_overlap: assert property (p_overlap) else $error("vertical gap");
   a_pix_busy: assert property (p_pix_busy) else $error("pixel in idle");
endmodule

bind ccdt_timing_gen ccdt_timing_gen_checker u_chk (.clk_sys, .nrst, .start, .busy,
   .frame_done, .vert_phase1_top, .vert_phase2_top, .vert_phase3_top, .vert_phase4_top,
   .v1_third_level, .horiz_ph2_storage, .last_horiz_phase, .cd_off_level,
   .substrate_pulse, .pixel_valid);

/* test/ccdt_timing_gen_bench.sv */
// self-checking bench of the timing generator with counts shrunk
// assumes the sensor model and the checker are compiled first
module ccdt_timing_gen_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, nrst = 1'b0, start = 1'b0, shutter_en = 1'b0;
   logic cd_off = 1'b0, clear = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [15:0] expose_lines = 16'h0000;
   logic [3:0] cd_seen, last_horiz_phase, cd_off_level;
   wire busy, frame_done, vert_phase1_bottom, v1_third_level, substrate_pulse, pixel_valid;
   wire vert_phase2_top, vert_phase2_bottom, vert_phase4_bottom;
   int err_count = 0, n_checks = 0, cyc = 0, pix_n = 0, sub_n = 0, row_count, pix_count;
   always #5 clk_sys = ~clk_sys;
   ccdt_timing_gen #(.LINES_HALF(4), .LINES_FULL(8), .PIX_DUAL(3), .PIX_SINGLE(6)) u_dut (
      .clk_sys(clk_sys), .nrst(nrst), .start(start), .mode(mode), .shutter_en(shutter_en),
      .expose_lines(expose_lines), .cd_off(cd_off), .busy(busy), .frame_done(frame_done),
      .vert_phase1_top(), .vert_phase2_top(vert_phase2_top), .vert_phase3_top(),
      .vert_phase4_top(), .vert_phase1_bottom(vert_phase1_bottom),
      .vert_phase2_bottom(vert_phase2_bottom), .vert_phase3_bottom(),
      .vert_phase4_bottom(vert_phase4_bottom), .v1_third_level(v1_third_level),
      .horiz_ph1_storage(),
      .horiz_ph1_barrier(), .horiz_ph2_storage(), .horiz_ph2_barrier(),
      .last_horiz_phase(last_horiz_phase), .reset_gate(), .cd_off_level(cd_off_level),
      .substrate_pulse(substrate_pulse), .pixel_valid(pixel_valid));
   ccdt_sensor_model u_sensor (.clear(clear), .vert_phase1_bottom(vert_phase1_bottom),
      .v1_third_level(v1_third_level), .last_horiz_a(last_horiz_phase[0]),
      .row_count(row_count), .pix_count(pix_count), .video_out_a());
   // ----
   // counters and hang limit
   // ----
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      pix_n <= clear ? 0 : pix_n + int'(pixel_valid === 1'b1);
      sub_n <= clear ? 0 : sub_n + int'(substrate_pulse === 1'b1);
      if (cyc == 50000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // one frame; a second start is poked mid-frame when poke is not negative
   task automatic run_frame(input logic [1:0] m, input logic sh, input logic cd, input int poke);
      int n;
      int bad;
      n = 0;
      bad = 0;
      mode <= m;
      shutter_en <= sh;
      cd_off <= cd;
      start <= 1'b1;
      clear <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      clear <= 1'b0;
      while (n < 20000) begin
         @(negedge clk_sys);
         if (frame_done === 1'b1) break;
         if (n == 50) cd_seen = cd_off_level;
         // full-height modes swap top phases two and four; sample 0 still shows the old mode
         if (n > 0 && vert_phase2_top !== (m[0] ? vert_phase4_bottom : vert_phase2_bottom))
            bad++;
         @(posedge clk_sys);
         start <= (n == poke);
         n++;
      end
      check(frame_done, 1'b1);
      check(bad, 0);
      // second edge lets the counters take the last pulse before they are read
      repeat (2) @(posedge clk_sys);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_modes;
      logic [3:0] cd_exp [4] = '{4'h0, 4'hC, 4'h0, 4'hC};
      int lin;
      int pix;
      for (int m = 0; m < 4; m++) begin
         run_frame(m[1:0], 1'b0, 1'b1, -1);
         lin = m[0] ? 8 : 4;
         pix = (m == 3) ? 6 : 3;
         check(row_count >= lin ? lin : row_count, lin);
         check(row_count, lin);
         check(pix_count >= lin * pix ? lin * pix : pix_count, lin * pix);
         check(pix_n >= lin * pix ? lin * pix : pix_n, lin * pix);
         check(cd_seen, cd_exp[m]);
         check(sub_n, 0);
      end
      $display("t_modes done");
   endtask
   task automatic t_shutter;
      expose_lines <= 16'h0032;
      run_frame(2'h1, 1'b1, 1'b0, -1);
      check(sub_n >= 100 ? 100 : sub_n, 100);
      check(cd_seen, 4'h0);
      $display("t_shutter done");
   endtask
   task automatic t_refuse;
      run_frame(2'h2, 1'b0, 1'b0, 300);
      @(negedge clk_sys);
      check(busy, 1'b0);
      @(posedge clk_sys);
      $display("t_refuse done");
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      t_modes();
      t_shutter();
      t_refuse();
      stop_test();
   end
endmodule
